/* core/sbg_pkg.sv */
// Package of constants for the board glue logic
package sbg_pkg;
	// Interrupt input indices
	localparam int IRQ_UART = 0;
	localparam int IRQ_SCSI = 1;
	localparam int IRQ_FLOPPY = 2;
	localparam int IRQ_PRINTER = 3;
	localparam int IRQ_COUNT = 4;
	// General-purpose port layout
	localparam int GP_OUT_W = 8;
	localparam int GP_IN_W = 7;
	localparam int GP_HS_A = 0;
	localparam int GP_HS_B = 1;
	localparam int GP_STROBE = 2;
	localparam int GP_TIMER_FEED = 3;
	localparam int GP_SPARE = 4;
	localparam int GP_FDC_RESET = 5;
	localparam int GP_LOOPBACK = 6;
	localparam int GP_PRN_INIT = 7;
	localparam int GP_PRN_BUSY = 2;
	localparam int GP_DRIVE_READY = 3;
	localparam int GP_PRN_SELECT = 4;
	localparam int GP_PAPER_END = 5;
	localparam logic [7:0] GP_OUT_RESET = 8'h00;
	// Peripheral selects
	localparam int PCS_W = 6;
	localparam int PCS_USED = 5;
	// Address space
	localparam int ADDR_W = 20;
	localparam logic [19:0] ROM_MIN_BYTES = 20'h04000;
	localparam logic [19:0] ROM_MAX_BYTES = 20'h20000;
	localparam logic [19:0] EXP_BASE = 20'h80000;
	localparam logic [19:0] RAM_TOP_SMALL = 20'h40000;
	localparam logic [19:0] RAM_TOP_LARGE = 20'h80000;
	// Refresh timing
	localparam int CLK_MHZ = 100;
	localparam int REFRESH_US = 16;
	localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
	localparam logic [10:0] REFRESH_LAST = 11'(REFRESH_CYC - 1);
	// Baud generator
	localparam int BAUD_SEL_W = 4;
	localparam int XTAL_HZ = 3686400;
	localparam int BAUD_MIN = 50;
	localparam int BAUD_MAX = 115200;
	// DRAM access phases
	typedef enum logic [3:0] {
		SBG_RAM_IDLE = 4'b0001,
		SBG_RAM_RAS = 4'b0010,
		SBG_RAM_CAS = 4'b0100,
		SBG_RAM_DONE = 4'b1000
	} sbg_ram_state_t;
endpackage

/* core/sbg_glue.sv */
// Board glue: selects, interrupt edges, refresh, memory decode, UART port pins
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// (RULE_01) Peripheral selects combine five processor selects with local decode, no waits.
// (RULE_02) Interrupt 0 UART, 1 SCSI, 2 floppy, 3 printer acknowledge.
// (RULE_03) Each interrupt input detected on a rising edge, active high.
// (RULE_04) Firmware sets timer 0, fed by timer 2, for 18 ticks per second.
// (RULE_05) Timer 2 prescales; its 16 us period clocks timer 0.
// (RULE_06) Timer 1 external count input comes from the UART timer output.
// (RULE_07) Software programs timer 2 to expire each 16 us refresh interval.
// (RULE_08) Refresh channel steps a 20-bit address, paced by timer 2, never stops.
// (RULE_09) Shared DMA request chosen between floppy and SCSI by floppy control bit.
// (RULE_10) EPROM decode supports 16K through 128K bytes of ROM.
// (RULE_11) Software sets the upper memory select for zero waits, ready ignored.
// (RULE_12) DRAM timing built from processor control and status, no waits.
// (RULE_13) Density input low selects 64K devices, high selects 256K devices.
// (RULE_14) Lower and middle selects unused; RAM decodes address lines directly.
// (RULE_15) Expansion decodes upper 512K; upper select disables it over EPROM.
// (RULE_16) Per-channel independent receive and transmit baud, 50 to 115.2K.
// (RULE_17) Output pins 0,1 handshake out; input pins 0,1 handshake in.
// (RULE_18) Port is eight outputs and seven inputs; four handshake, eleven other.
// (RULE_19) Out pins: 2 strobe, 3 timer feed, 4 spare, 5 floppy reset, 7 init.
// (RULE_20) In pins: 2 busy, 3 drive ready, 4 printer select, 5 paper end.
// (RULE_21) Pin 6 open drain, looped to input 6 and jumper; readable when high.
// (RULE_22) Output pins invert their register bits; inputs read without inversion.
// (RULE_23) Floppy controller held in reset while output pin 5 is low.
module sbg_glue
	import sbg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [PCS_W-1:0] periph_selects,
	input wire logic [2:0] io_sub_addr,
	output logic [7:0] io_dev_sel,
	input wire logic irq_in_uart,
	input wire logic irq_in_scsi,
	input wire logic irq_in_floppy,
	input wire logic irq_in_printer,
	output logic [IRQ_COUNT-1:0] irq_edge,
	input wire logic uart_timer_out,
	output logic timer1_count_in,
	output logic timer0_count_in,
	output logic refresh_req,
	output logic [ADDR_W-1:0] refresh_addr,
	input wire logic dma_route_scsi,
	input wire logic fdc_dma_req,
	input wire logic scsi_dma_req,
	output logic shared_dma_req,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic cpu_mem_strobe,
	input wire logic upper_mem_select,
	input wire logic lower_mem_select,
	input wire logic middle_mem_select,
	input wire logic [1:0] rom_size_sel,
	input wire logic ram_density,
	output logic rom_sel,
	output logic ram_ras,
	output logic ram_cas,
	output logic exp_sel,
	input wire logic [BAUD_SEL_W-1:0] baud_rx_a,
	input wire logic [BAUD_SEL_W-1:0] baud_tx_a,
	input wire logic [BAUD_SEL_W-1:0] baud_rx_b,
	input wire logic [BAUD_SEL_W-1:0] baud_tx_b,
	input wire logic baud_tick,
	output logic [3:0] baud_en,
	input wire logic gp_wr,
	input wire logic [GP_OUT_W-1:0] gp_set_bits,
	input wire logic [GP_OUT_W-1:0] gp_clr_bits,
	output logic gp_out_hs_a,
	output logic gp_out_hs_b,
	output logic gp_out_strobe,
	output logic gp_out_timer_feed,
	output logic gp_out_spare,
	output logic gp_out_fdc_reset,
	output logic gp_out_loopback_o,
	output logic gp_out_loopback_oe,
	output logic gp_out_prn_init,
	output logic fdc_reset_hold,
	input wire logic hs_in_chan_a,
	input wire logic hs_in_chan_b,
	input wire logic gp_in_prn_busy,
	input wire logic gp_in_drive_ready,
	input wire logic gp_in_prn_select,
	input wire logic gp_in_paper_end,
	input wire logic gp_in_loopback,
	output logic [GP_IN_W-1:0] gp_in_value
);

	// ------------------------------------------------------------
	// Peripheral selects
	// ------------------------------------------------------------
	logic [7:0] io_dev_sel_reg, io_dev_sel_next;

	// Local decode qualified by five selects, no wait states
	always_comb begin
		io_dev_sel_next = 8'h00;
		for (int i = 0; i < PCS_USED; i++) begin
			if (periph_selects[i]) begin
				io_dev_sel_next = io_dev_sel_next | (8'h01 << io_sub_addr); // [RULE_01]
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			io_dev_sel_reg <= 8'h00;
		end else begin
			io_dev_sel_reg <= io_dev_sel_next;
		end
	end
	assign io_dev_sel = io_dev_sel_reg;

	// ------------------------------------------------------------
	// Interrupt edge detection
	// ------------------------------------------------------------
	logic [IRQ_COUNT-1:0] irq_lvl;
	logic [IRQ_COUNT-1:0] irq_prev_reg, irq_prev_next;
	logic [IRQ_COUNT-1:0] irq_edge_reg, irq_edge_next;

	// Fixed routing of the four sources
	assign irq_lvl[IRQ_UART] = irq_in_uart; // [RULE_02]
	assign irq_lvl[IRQ_SCSI] = irq_in_scsi; // [RULE_02]
	assign irq_lvl[IRQ_FLOPPY] = irq_in_floppy; // [RULE_02]
	assign irq_lvl[IRQ_PRINTER] = irq_in_printer; // [RULE_02]

	// Rising edge, active high, one pulse per edge
	generate
		for (genvar g = 0; g < IRQ_COUNT; g++) begin : g_irq
			always_comb begin
				irq_prev_next[g] = irq_lvl[g];
				irq_edge_next[g] = irq_lvl[g] & ~irq_prev_reg[g]; // [RULE_03]
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_prev_reg <= '0;
			irq_edge_reg <= '0;
		end else begin
			irq_prev_reg <= irq_prev_next;
			irq_edge_reg <= irq_edge_next;
		end
	end
	assign irq_edge = irq_edge_reg;

	// ------------------------------------------------------------
	// Timers, refresh and shared DMA
	// ------------------------------------------------------------
	logic [10:0] pre_cnt_reg, pre_cnt_next;
	logic pre_tick_reg, pre_tick_next;
	logic t1_in_reg, t1_in_next;
	logic [ADDR_W-1:0] ref_addr_reg, ref_addr_next;
	logic dma_req_reg, dma_req_next;

	// Prescaler period paces timer 0 and refresh
	always_comb begin
		pre_tick_next = 1'b0;
		if (pre_cnt_reg == REFRESH_LAST) begin
			pre_cnt_next = 11'h000;
			pre_tick_next = 1'b1; // [RULE_05]
		end else begin
			pre_cnt_next = pre_cnt_reg + 11'h001;
		end
		t1_in_next = uart_timer_out; // [RULE_06]
		// Free-running wrap, no terminal count
		ref_addr_next = pre_tick_reg ? ref_addr_reg + 20'h00001 : ref_addr_reg; // [RULE_08]
		dma_req_next = dma_route_scsi ? scsi_dma_req : fdc_dma_req; // [RULE_09]
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pre_cnt_reg <= 11'h000;
			pre_tick_reg <= 1'b0;
			t1_in_reg <= 1'b0;
			ref_addr_reg <= '0;
			dma_req_reg <= 1'b0;
		end else begin
			pre_cnt_reg <= pre_cnt_next;
			pre_tick_reg <= pre_tick_next;
			t1_in_reg <= t1_in_next;
			ref_addr_reg <= ref_addr_next;
			dma_req_reg <= dma_req_next;
		end
	end
	assign timer0_count_in = pre_tick_reg;
	assign refresh_req = pre_tick_reg;
	assign refresh_addr = ref_addr_reg;
	assign timer1_count_in = t1_in_reg;
	assign shared_dma_req = dma_req_reg;

	// ------------------------------------------------------------
	// Memory decode and DRAM timing
	// ------------------------------------------------------------
	sbg_ram_state_t ram_state_reg, ram_state_next;
	logic [ADDR_W-1:0] rom_bytes;
	logic [ADDR_W-1:0] ram_top;
	logic ram_hit;
	logic rom_sel_reg, rom_sel_next;
	logic exp_sel_reg, exp_sel_next;
	logic ras_reg, ras_next;
	logic cas_reg, cas_next;

	// ROM size 16K shifted up to 128K
	always_comb begin
		rom_bytes = ROM_MIN_BYTES << rom_size_sel; // [RULE_10]
		if (rom_bytes > ROM_MAX_BYTES) begin
			rom_bytes = ROM_MAX_BYTES;
		end
		ram_top = ram_density ? RAM_TOP_LARGE : RAM_TOP_SMALL; // [RULE_13]
		// Lower and middle selects ignored; address lines decoded
		ram_hit = cpu_addr < ram_top; // [RULE_14]
	end

	// Select decode, upper select masks expansion over EPROM
	always_comb begin
		rom_sel_next = cpu_mem_strobe & upper_mem_select &
			(cpu_addr >= (20'hFFFFF - rom_bytes + 20'h00001)); // [RULE_10]
		exp_sel_next = cpu_mem_strobe & (cpu_addr >= EXP_BASE) & ~upper_mem_select; // [RULE_15]
	end

	// DRAM strobes straight from status, no wait state
	always_comb begin
		ram_state_next = ram_state_reg;
		ras_next = 1'b0;
		cas_next = 1'b0;
		unique case (ram_state_reg)
			SBG_RAM_IDLE: begin
				if (cpu_mem_strobe & ram_hit) begin
					ram_state_next = SBG_RAM_RAS;
					ras_next = 1'b1; // [RULE_12]
				end
			end
			SBG_RAM_RAS: begin
				ram_state_next = SBG_RAM_CAS;
				ras_next = 1'b1;
				cas_next = 1'b1; // [RULE_12]
			end
			SBG_RAM_CAS: begin
				ras_next = cpu_mem_strobe;
				cas_next = cpu_mem_strobe;
				if (!cpu_mem_strobe) begin
					ram_state_next = SBG_RAM_DONE;
				end
			end
			SBG_RAM_DONE: begin
				ram_state_next = SBG_RAM_IDLE;
			end
			default: begin
				ram_state_next = SBG_RAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ram_state_reg <= SBG_RAM_IDLE;
			rom_sel_reg <= 1'b0;
			exp_sel_reg <= 1'b0;
			ras_reg <= 1'b0;
			cas_reg <= 1'b0;
		end else begin
			ram_state_reg <= ram_state_next;
			rom_sel_reg <= rom_sel_next;
			exp_sel_reg <= exp_sel_next;
			ras_reg <= ras_next;
			cas_reg <= cas_next;
		end
	end
	assign rom_sel = rom_sel_reg;
	assign exp_sel = exp_sel_reg;
	assign ram_ras = ras_reg;
	assign ram_cas = cas_reg;

	// ------------------------------------------------------------
	// Baud enables
	// ------------------------------------------------------------
	logic [15:0] baud_div_reg, baud_div_next;
	logic [3:0] baud_en_reg, baud_en_next;
	logic [BAUD_SEL_W-1:0] baud_sel [4];

	assign baud_sel[0] = baud_rx_a;
	assign baud_sel[1] = baud_tx_a;
	assign baud_sel[2] = baud_rx_b;
	assign baud_sel[3] = baud_tx_b;

	// Each direction taps its own divider bit
	always_comb begin
		baud_div_next = baud_tick ? baud_div_reg + 16'h0001 : baud_div_reg;
		for (int i = 0; i < 4; i++) begin
			baud_en_next[i] = baud_tick &
				(baud_div_reg[baud_sel[i]] & ~baud_div_next[baud_sel[i]]); // [RULE_16]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			baud_div_reg <= 16'h0000;
			baud_en_reg <= 4'h0;
		end else begin
			baud_div_reg <= baud_div_next;
			baud_en_reg <= baud_en_next;
		end
	end
	assign baud_en = baud_en_reg;

	// ------------------------------------------------------------
	// General-purpose port
	// ------------------------------------------------------------
	logic [GP_OUT_W-1:0] gp_reg, gp_next;
	logic [GP_OUT_W-1:0] gp_pin_reg, gp_pin_next;
	logic [GP_IN_W-1:0] gp_in_reg, gp_in_next;
	logic fdc_hold_reg, loop_oe_reg;

	// Set and clear commands, set wins
	always_comb begin
		gp_next = gp_reg;
		if (gp_wr) begin
			gp_next = (gp_reg & ~gp_clr_bits) | gp_set_bits;
		end
		gp_pin_next = ~gp_next; // [RULE_22]
		gp_in_next[GP_HS_A] = hs_in_chan_a; // [RULE_17]
		gp_in_next[GP_HS_B] = hs_in_chan_b; // [RULE_17]
		gp_in_next[GP_PRN_BUSY] = gp_in_prn_busy; // [RULE_20]
		gp_in_next[GP_DRIVE_READY] = gp_in_drive_ready; // [RULE_20]
		gp_in_next[GP_PRN_SELECT] = gp_in_prn_select; // [RULE_20]
		gp_in_next[GP_PAPER_END] = gp_in_paper_end; // [RULE_20]
		gp_in_next[GP_LOOPBACK] = gp_in_loopback; // [RULE_21]
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gp_reg <= GP_OUT_RESET;
			gp_pin_reg <= ~GP_OUT_RESET;
			gp_in_reg <= '0;
			fdc_hold_reg <= GP_OUT_RESET[GP_FDC_RESET];
			loop_oe_reg <= GP_OUT_RESET[GP_LOOPBACK];
		end else begin
			gp_reg <= gp_next;
			gp_pin_reg <= gp_pin_next;
			fdc_hold_reg <= gp_next[GP_FDC_RESET]; // [RULE_23]
			loop_oe_reg <= gp_next[GP_LOOPBACK]; // [RULE_21]
			gp_in_reg <= gp_in_next; // [RULE_18]
		end
	end

	assign gp_out_hs_a = gp_pin_reg[GP_HS_A]; // [RULE_17]
	assign gp_out_hs_b = gp_pin_reg[GP_HS_B]; // [RULE_17]
	assign gp_out_strobe = gp_pin_reg[GP_STROBE]; // [RULE_19]
	assign gp_out_timer_feed = gp_pin_reg[GP_TIMER_FEED]; // [RULE_19]
	assign gp_out_spare = gp_pin_reg[GP_SPARE]; // [RULE_19]
	assign gp_out_fdc_reset = gp_pin_reg[GP_FDC_RESET]; // [RULE_19]
	assign gp_out_prn_init = gp_pin_reg[GP_PRN_INIT]; // [RULE_19]
	// Open drain: only pulls low, released when high
	assign gp_out_loopback_o = 1'b0;
	assign gp_out_loopback_oe = loop_oe_reg; // [RULE_21]
	// Floppy reset held while pin 5 low
	assign fdc_reset_hold = fdc_hold_reg; // [RULE_23]
	assign gp_in_value = gp_in_reg;

endmodule

`default_nettype wire

/* dv/sbg_far_end.sv */
// Model of the pin side: open-drain loop pin with pull-up and jumper
`timescale 1ns/100ps
`default_nettype none
module sbg_far_end (
	input wire logic drive_oe,
	input wire logic drive_o,
	input wire logic jumper_on,
	output logic pin_level
);
	// ----------------------------------------
	// Wired level of the loop pin
	// ----------------------------------------
	// Pull-up wins unless the port sinks it or the jumper grounds it
	assign pin_level = !((drive_oe && !drive_o) || jumper_on);
endmodule
`default_nettype wire

/* dv/sbg_glue_assertions.sv */
// Checker of port relations for the board glue
`timescale 1ns/100ps
`default_nettype none
module sbg_glue_assertions
	import sbg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [PCS_W-1:0] periph_selects,
	input wire logic [2:0] io_sub_addr,
	input wire logic [7:0] io_dev_sel,
	input wire logic irq_in_uart,
	input wire logic irq_in_scsi,
	input wire logic irq_in_floppy,
	input wire logic irq_in_printer,
	input wire logic [IRQ_COUNT-1:0] irq_edge,
	input wire logic uart_timer_out,
	input wire logic timer1_count_in,
	input wire logic timer0_count_in,
	input wire logic refresh_req,
	input wire logic [ADDR_W-1:0] refresh_addr,
	input wire logic dma_route_scsi,
	input wire logic fdc_dma_req,
	input wire logic scsi_dma_req,
	input wire logic shared_dma_req,
	input wire logic gp_wr,
	input wire logic [GP_OUT_W-1:0] gp_set_bits,
	input wire logic gp_out_fdc_reset,
	input wire logic gp_out_loopback_o,
	input wire logic fdc_reset_hold
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [3:0] irq_d_reg;
	logic [3:0] irq_r_reg;
	logic [10:0] gap_reg;
	logic seen_reg;
	wire [3:0] irq_v = {irq_in_printer, irq_in_floppy, irq_in_scsi, irq_in_uart};
	wire pcs_any = |periph_selects[PCS_USED-1:0];
	// ----------------------------------------
	// Reference edge finder and refresh gap
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_d_reg <= 4'h0;
			irq_r_reg <= 4'h0;
			gap_reg <= 11'h000;
			seen_reg <= 1'b0;
		end else begin
			irq_d_reg <= irq_v;
			irq_r_reg <= irq_v & ~irq_d_reg;
			gap_reg <= refresh_req ? 11'h000 : gap_reg + 11'h001;
			seen_reg <= seen_reg | refresh_req;
		end
	end
	sequence fdc_set_s;
		gp_wr && gp_set_bits[GP_FDC_RESET];
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	irq_edge_a: assert property (irq_edge == irq_r_reg)
		else $error("interrupt edge pulse wrong");
	sel_hot_a: assert property (!$past(rst) && $past(pcs_any) |-> io_dev_sel == 8'h01 << $past(io_sub_addr))
		else $error("device select not one-hot");
	timer_feed_a: assert property (!$past(rst) |-> timer1_count_in == $past(uart_timer_out))
		else $error("timer 1 input not following");
	tick_pair_a: assert property (timer0_count_in == refresh_req)
		else $error("prescale tick differs from refresh");
	gap_exact_a: assert property (refresh_req && seen_reg |-> gap_reg == REFRESH_LAST)
		else $error("refresh period wrong");
	never_stop_a: assert property (seen_reg |-> gap_reg <= REFRESH_LAST)
		else $error("refresh stopped");
	addr_step_a: assert property (refresh_req |-> ##1 refresh_addr == $past(refresh_addr) + 20'h00001)
		else $error("refresh address not stepping");
	dma_mux_a: assert property (!$past(rst) |->
		shared_dma_req == ($past(dma_route_scsi) ? $past(scsi_dma_req) : $past(fdc_dma_req)))
		else $error("shared request wrong source");
	fdc_set_a: assert property (fdc_set_s |=> !gp_out_fdc_reset && fdc_reset_hold)
		else $error("floppy reset not driven");
	hold_tie_a: assert property (fdc_reset_hold == !gp_out_fdc_reset)
		else $error("floppy hold not tied to pin");
	loop_od_a: assert property (!gp_out_loopback_o)
		else $error("loop pin drives high");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the board glue
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sbg_pkg::*;
	logic clk_sys = 0, rst = 1;
	logic [5:0] periph_selects = 6'h00, gin = 6'h00;
	logic [2:0] io_sub_addr = 3'h0, dmav = 3'h0;
	logic [3:0] irqv = 4'h0, baud_rx_a = 4'h0, baud_tx_a = 4'h0, baud_rx_b = 4'h0, baud_tx_b = 4'h0;
	logic uart_timer_out = 0, cpu_mem_strobe = 0, upper_mem_select = 0, lower_mem_select = 0;
	logic middle_mem_select = 0, ram_density = 0, baud_tick = 0, gp_wr = 0, jumper_on = 0;
	logic [19:0] cpu_addr = 20'h00000;
	logic [1:0] rom_size_sel = 2'h0;
	logic [7:0] gp_set_bits = 8'h00, gp_clr_bits = 8'h00, io_dev_sel;
	logic [3:0] irq_edge, baud_en;
	logic [19:0] refresh_addr, a;
	logic [6:0] gp_in_value;
	logic [35:0] mt [6] = '{36'h0110FC000, 36'h0010FB000, 36'h0111F8000, 36'h0113E0000, 36'h0013DF000, 36'h100090000};
	logic timer1_count_in, timer0_count_in, refresh_req, shared_dma_req, rom_sel, ram_ras, ram_cas, exp_sel;
	logic gp_out_hs_a, gp_out_hs_b, gp_out_strobe, gp_out_timer_feed, gp_out_spare, gp_out_fdc_reset;
	logic gp_out_loopback_o, gp_out_loopback_oe, gp_out_prn_init, fdc_reset_hold, gp_in_loopback;
	wire [7:0] pins = {gp_out_prn_init, gp_in_loopback, gp_out_fdc_reset, gp_out_spare,
		gp_out_timer_feed, gp_out_strobe, gp_out_hs_b, gp_out_hs_a};
	int n_fail = 0, n_checks = 0, i, k, j;
	int bc [4] = '{0, 0, 0, 0};
	sbg_glue i_dut (.*, .irq_in_uart(irqv[0]), .irq_in_scsi(irqv[1]), .irq_in_floppy(irqv[2]),
		.irq_in_printer(irqv[3]), .dma_route_scsi(dmav[2]), .fdc_dma_req(dmav[1]), .scsi_dma_req(dmav[0]),
		.hs_in_chan_a(gin[0]), .hs_in_chan_b(gin[1]), .gp_in_prn_busy(gin[2]), .gp_in_drive_ready(gin[3]),
		.gp_in_prn_select(gin[4]), .gp_in_paper_end(gin[5]));
	sbg_far_end i_far (.drive_oe(gp_out_loopback_oe), .drive_o(gp_out_loopback_o), .jumper_on(jumper_on),
		.pin_level(gp_in_loopback));
	// ----------------------------------------
	// Clock and helpers
	// ----------------------------------------
	always #5 clk_sys = ~clk_sys;
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task look;
		@(negedge clk_sys);
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task gp(input logic [7:0] s, input logic [7:0] c);
		cyc(1);
		gp_wr <= 1'b1;
		gp_set_bits <= s;
		gp_clr_bits <= c;
		cyc(1);
		gp_wr <= 1'b0;
		look;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000;
		n_fail++;
		print_verdict;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		cyc(4);
		rst <= 1'b0;
		look;
		chk(pins, 8'hFF);
		chk({fdc_reset_hold, gp_out_loopback_oe, irq_edge}, 6'h00);
		for (i = 0; i < 8; i++) begin
			gp(8'h01 << i, 8'h00);
			chk(pins, 8'(~(8'h01 << i)));
			chk(fdc_reset_hold, i == 5);
			gp(8'h00, 8'h01 << i);
			chk(pins, 8'hFF);
		end
		gp(8'h01, 8'h01);
		chk(pins, 8'hFE);
		$display("test gp outputs done");
		cyc(1);
		jumper_on <= 1'b1;
		cyc(2);
		look;
		chk(gp_in_value[6], 1'b0);
		cyc(1);
		jumper_on <= 1'b0;
		gp(8'h40, 8'h00);
		cyc(1);
		look;
		chk(gp_in_value[6], 1'b0);
		gp(8'h00, 8'h40);
		for (i = 0; i < 6; i++) begin
			cyc(1);
			gin <= 6'h01 << i;
			cyc(2);
			look;
			chk(gp_in_value, 7'h40 | (7'h01 << i));
		end
		$display("test loop and inputs done");
		for (i = 0; i < 4; i++) begin
			cyc(1);
			irqv <= 4'h1 << i;
			cyc(1);
			look;
			chk(irq_edge, 4'h1 << i);
			cyc(1);
			irqv <= 4'h0;
			look;
			chk(irq_edge, 4'h0);
		end
		for (k = 0; k < 8; k++) begin
			cyc(1);
			dmav <= k[2:0];
			periph_selects <= 6'h01 << k[2:0];
			io_sub_addr <= 3'(7 - k);
			uart_timer_out <= k[0];
			cyc(1);
			look;
			chk(shared_dma_req, k[2] ? k[0] : k[1]);
			chk(io_dev_sel, k < 5 ? 8'h80 >> k : 8'h00);
			chk(timer1_count_in, k[0]);
		end
		$display("test irq dma selects done");
		for (k = 0; k < 6; k++) begin
			cyc(1);
			cpu_mem_strobe <= 1'b1;
			upper_mem_select <= mt[k][24];
			rom_size_sel <= mt[k][21:20];
			cpu_addr <= mt[k][19:0];
			cyc(1);
			look;
			chk({exp_sel, rom_sel}, {mt[k][32], mt[k][28]});
		end
		cyc(1);
		cpu_mem_strobe <= 1'b0;
		upper_mem_select <= 1'b0;
		cpu_addr <= 20'h50000;
		cyc(3);
		cpu_mem_strobe <= 1'b1;
		cyc(2);
		look;
		chk(ram_ras, 1'b0);
		cyc(1);
		cpu_mem_strobe <= 1'b0;
		cyc(3);
		ram_density <= 1'b1;
		lower_mem_select <= 1'b1;
		middle_mem_select <= 1'b1;
		cpu_mem_strobe <= 1'b1;
		cyc(1);
		look;
		chk({ram_ras, ram_cas}, 2'h2);
		look;
		chk({ram_ras, ram_cas}, 2'h3);
		$display("test memory done");
		i = 0;
		do begin
			look;
			i++;
		end while (refresh_req !== 1'b1 && i < 1700);
		a = refresh_addr;
		i = 0;
		do begin
			look;
			i++;
		end while (refresh_req !== 1'b1 && i < 1700);
		chk(i, REFRESH_CYC);
		chk(timer0_count_in, 1'b1);
		chk(refresh_addr, a + 20'h00001);
		cyc(1);
		baud_tick <= 1'b1;
		k = 0;
		for (i = 0; i < 9; i++) begin
			look;
			k += (baud_en === 4'hF);
		end
		chk(k, 4);
		// Independent taps per direction
		cyc(1);
		baud_tx_a <= 4'h1;
		baud_rx_b <= 4'h2;
		baud_tx_b <= 4'h3;
		look;
		repeat (16) begin
			look;
			for (j = 0; j < 4; j++) begin
				bc[j] += baud_en[j];
			end
		end
		chk(bc[0], 8);
		chk(bc[1], 4);
		chk(bc[2], 2);
		chk(bc[3], 1);
		$display("test refresh and baud done");
		print_verdict;
	end
endmodule
bind sbg_glue sbg_glue_assertions i_chk (.*);
`default_nettype wire
